//--- rtl/cmsd_pkg.sv
`default_nettype none
package cmsd_pkg;
   // Program memory map
   localparam logic [15:0] CMSD_RESET_VEC = 16'h0000;
   localparam logic [15:0] CMSD_VEC_BASE = 16'h0003;
   localparam int CMSD_VEC_SPACING = 8;
   localparam int CMSD_VEC_COUNT = 16;
   localparam int CMSD_PC_W = 16;
   localparam int CMSD_ROM_BYTES = 4096;
   localparam int CMSD_ROM_AW = 12;
   // Data memory map
   localparam int CMSD_RAM_BYTES = 256;
   localparam logic [7:0] CMSD_LOWER_TOP = 8'h7f;
   localparam logic [7:0] CMSD_BIT_BASE = 8'h20;
   localparam logic [4:0] CMSD_BANK_BYTES_LOG = 5'd3;
   // Special-function addresses and resets
   localparam logic [7:0] CMSD_ACC_ADDR = 8'he0;
   localparam logic [7:0] CMSD_ACC_RESET = 8'h00;
   localparam logic [7:0] CMSD_PSW_ADDR = 8'hd0;
   localparam logic [7:0] CMSD_PSW_RESET = 8'h00;
   localparam int CMSD_PSW_BS_HI = 4;
   localparam int CMSD_PSW_BS_LO = 3;
   // Option memory
   localparam logic [15:0] CMSD_OPT_ZERO_OFS_ADDR = 16'h4007;

   typedef enum logic [1:0] {
      CMSD_MODE_DIRECT,
      CMSD_MODE_INDIRECT,
      CMSD_MODE_REG,
      CMSD_MODE_BIT
   } cmsd_mode_t;

   typedef struct packed {
      logic req;
      logic wr;
      cmsd_mode_t mode;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cmsd_dreq_t;
endpackage : cmsd_pkg
`default_nettype wire

//--- rtl/cmsd_ram.sv
`default_nettype none
module cmsd_ram
   import cmsd_pkg::*;
#(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clock_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clock_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule : cmsd_ram
`default_nettype wire

//--- rtl/cmsd_decoder.sv
`default_nettype none
module cmsd_decoder
   import cmsd_pkg::*;
#(
   parameter int ROM_BYTES = CMSD_ROM_BYTES,
   parameter int VEC_COUNT = CMSD_VEC_COUNT
) (
   input wire logic clock_i,
   input wire logic reset_i,
   // Program fetch
   input wire logic fetch_req_i,
   input wire logic fetch_jump_i,
   input wire logic [CMSD_PC_W-1:0] fetch_target_i,
   input wire logic vec_take_i,
   input wire logic [3:0] vec_index_i,
   output logic [CMSD_PC_W-1:0] pc_o,
   output logic [CMSD_PC_W-1:0] rom_addr_o,
   output logic rom_en_o,
   output logic opt_sel_o,
   // Data access
   input wire cmsd_dreq_t dreq_i,
   input wire logic [7:0] psw_flags_i,
   input wire logic psw_flags_we_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic bit_o,
   output logic [7:0] arith_working_reg_o,
   output logic [7:0] program_status_word_o,
   output logic [1:0] bank_o
);
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [CMSD_PC_W-1:0] pc;
      logic [CMSD_PC_W-1:0] rom_addr;
      logic rom_en;
      logic opt_sel;
      logic [7:0] acc;
      logic [7:0] program_status_word;
      logic [7:0] sfr_rdata;
      logic sfr_hit;
      logic rvalid;
      logic [2:0] bit_sel;
      logic bit_mode;
      logic [7:0] rdata;
      logic bit_val;
      logic rvalid_out;
   } cmsd_state_t;

   cmsd_state_t state_q;
   cmsd_state_t state_d;

   ////////////////////////////////////////////////////////////////////
   function automatic logic [CMSD_PC_W-1:0] vec_addr(input logic [3:0] idx);
      vec_addr = CMSD_VEC_BASE + CMSD_PC_W'(idx) * CMSD_PC_W'(CMSD_VEC_SPACING);
   endfunction : vec_addr

   function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] r);
      bank_addr = {3'h0, bank, r};
   endfunction : bank_addr

   function automatic logic [7:0] bit_byte(input logic [6:0] b);
      bit_byte = CMSD_BIT_BASE + 8'(b[6:3]);
   endfunction : bit_byte

   function automatic logic sfr_match(input cmsd_mode_t m, input logic [7:0] a,
         input logic [7:0] target);
      // Bit addresses name the byte whose address has the low three bits clear
      if (m == CMSD_MODE_BIT) begin
         sfr_match = {a[7:3], 3'h0} == target;
      end else begin
         sfr_match = a == target;
      end
   endfunction : sfr_match

   function automatic logic [1:0] bank_of(input logic [7:0] program_status_word);
      bank_of = {program_status_word[CMSD_PSW_BS_HI], program_status_word[CMSD_PSW_BS_LO]};
   endfunction : bank_of

   ////////////////////////////////////////////////////////////////////
   logic [1:0] bank_sel;
   logic upper;
   logic to_sfr;
   logic to_ram;
   logic [7:0] ram_addr;
   logic ram_we;
   logic [7:0] ram_rdata;
   logic [CMSD_PC_W-1:0] next_pc;

   assign bank_sel = bank_of(state_q.program_status_word);
   assign upper = dreq_i.addr > CMSD_LOWER_TOP;

   always_comb begin
      to_sfr = 1'b0;
      to_ram = 1'b0;
      ram_addr = dreq_i.addr;
      unique case (dreq_i.mode)
         CMSD_MODE_DIRECT: begin
            to_sfr = upper;
            to_ram = !upper;
         end
         CMSD_MODE_INDIRECT: begin
            to_ram = 1'b1;
         end
         CMSD_MODE_REG: begin
            to_ram = 1'b1;
            ram_addr = bank_addr(bank_sel, dreq_i.addr[2:0]);
         end
         CMSD_MODE_BIT: begin
            to_sfr = dreq_i.addr[7];
            to_ram = !dreq_i.addr[7];
            ram_addr = bit_byte(dreq_i.addr[6:0]);
         end
      endcase
   end

   // Bit writes are handled by the core as read-modify-write byte stores
   assign ram_we = dreq_i.req && dreq_i.wr && to_ram && dreq_i.mode != CMSD_MODE_BIT;

   cmsd_ram #(
      .DEPTH(CMSD_RAM_BYTES),
      .AW(8)
   ) u_ram (
      .clock_i(clock_i),
      .we_i(ram_we),
      .waddr_i(ram_addr),
      .wdata_i(dreq_i.wdata),
      .raddr_i(ram_addr),
      .rdata_o(ram_rdata)
   );

   always_comb begin
      if (fetch_jump_i) begin
         next_pc = fetch_target_i;
      end else begin
         next_pc = state_q.pc + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      state_d.rom_en = 1'b0;
      state_d.rvalid = 1'b0;
      state_d.rvalid_out = state_q.rvalid;
      // Vector slots are ordinary locations; only a taken interrupt jumps there
      if (vec_take_i && 32'(vec_index_i) < VEC_COUNT) begin
         state_d.pc = vec_addr(vec_index_i);
      end else if (fetch_req_i) begin
         state_d.rom_addr = state_q.pc;
         state_d.rom_en = 32'(state_q.pc) < ROM_BYTES;
         state_d.opt_sel = state_q.pc == CMSD_OPT_ZERO_OFS_ADDR;
         state_d.pc = next_pc;
      end
      if (psw_flags_we_i) begin
         state_d.program_status_word = psw_flags_i;
      end
      if (dreq_i.req) begin
         state_d.bit_sel = dreq_i.addr[2:0];
         state_d.bit_mode = dreq_i.mode == CMSD_MODE_BIT;
         state_d.sfr_hit = to_sfr;
         state_d.sfr_rdata = 8'h00;
         if (to_sfr) begin
            if (sfr_match(dreq_i.mode, dreq_i.addr, CMSD_ACC_ADDR)) begin
               state_d.sfr_rdata = state_q.acc;
               if (dreq_i.wr && dreq_i.mode == CMSD_MODE_DIRECT) begin
                  state_d.acc = dreq_i.wdata;
               end
            end else if (sfr_match(dreq_i.mode, dreq_i.addr, CMSD_PSW_ADDR)) begin
               state_d.sfr_rdata = state_q.program_status_word;
               if (dreq_i.wr && dreq_i.mode == CMSD_MODE_DIRECT) begin
                  state_d.program_status_word = dreq_i.wdata;
               end
            end
         end
         state_d.rvalid = !dreq_i.wr;
      end
      if (state_q.rvalid) begin
         state_d.rdata = state_q.sfr_hit ? state_q.sfr_rdata : ram_rdata;
         state_d.bit_val = state_q.bit_mode
            ? (state_q.sfr_hit ? state_q.sfr_rdata[state_q.bit_sel]
               : ram_rdata[state_q.bit_sel])
            : 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_q <= '0;
         state_q.pc <= CMSD_RESET_VEC;
         state_q.acc <= CMSD_ACC_RESET;
         state_q.program_status_word <= CMSD_PSW_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign pc_o = state_q.pc;
   assign rom_addr_o = state_q.rom_addr;
   assign rom_en_o = state_q.rom_en;
   assign opt_sel_o = state_q.opt_sel;
   assign rdata_o = state_q.rdata;
   assign rvalid_o = state_q.rvalid_out;
   assign bit_o = state_q.bit_val;
   assign arith_working_reg_o = state_q.acc;
   assign program_status_word_o = state_q.program_status_word;
   assign bank_o = bank_of(state_q.program_status_word);

   ////////////////////////////////////////////////////////////////////
   reset_fetch_a: assert property (@(posedge clock_i) $fell(reset_i) |-> pc_o == 16'h0000)
      else $error("pc not zero after reset");
   vector_addr_a: assert property (@(posedge clock_i) disable iff (reset_i)
      vec_take_i && vec_index_i == 4'h0 |=> pc_o == 16'h0003)
      else $error("first vector not at 0003");
   vector_space_a: assert property (@(posedge clock_i) disable iff (reset_i)
      vec_take_i && vec_index_i == 4'h2 |=> pc_o == 16'h0013)
      else $error("vector spacing wrong");
   rom_range_a: assert property (@(posedge clock_i) disable iff (reset_i)
      rom_en_o |-> rom_addr_o < 16'h1000)
      else $error("rom enabled out of range");
   pc_step_a: assert property (@(posedge clock_i) disable iff (reset_i)
      fetch_req_i && !fetch_jump_i && !vec_take_i |=> pc_o == $past(pc_o) + 16'h0001)
      else $error("pc did not step");
   upper_direct_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.mode == CMSD_MODE_DIRECT && dreq_i.addr[7] |-> !ram_we)
      else $error("direct write reached upper ram");
   acc_write_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.wr && dreq_i.mode == CMSD_MODE_DIRECT
      && dreq_i.addr == 8'he0 |=> arith_working_reg_o == $past(dreq_i.wdata))
      else $error("accumulator write lost");
   bank_sel_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.wr && dreq_i.mode == CMSD_MODE_DIRECT && dreq_i.addr == 8'hd0
      |=> bank_o == {$past(dreq_i.wdata[4]), $past(dreq_i.wdata[3])})
      else $error("bank select mismatch");
   unmapped_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && !dreq_i.wr && dreq_i.mode == CMSD_MODE_DIRECT && dreq_i.addr[7]
      && dreq_i.addr != 8'he0 && dreq_i.addr != 8'hd0 |=> ##1 rvalid_o && rdata_o == 8'h00)
      else $error("unmapped sfr read not zero");

   // Reset and fetch path checks
   reset_state_a: assert property (@(posedge clock_i) $fell(reset_i)
      |-> arith_working_reg_o == 8'h00 && program_status_word_o == 8'h00)
      else $error("registers not cleared by reset");
   rom_enable_a: assert property (@(posedge clock_i) disable iff (reset_i)
      fetch_req_i && !vec_take_i && pc_o < 16'h1000 |=> rom_en_o)
      else $error("populated fetch not enabled");
   rom_block_a: assert property (@(posedge clock_i) disable iff (reset_i)
      fetch_req_i && !vec_take_i && pc_o >= 16'h1000 |=> !rom_en_o)
      else $error("unpopulated fetch enabled");
   rom_pulse_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !fetch_req_i || vec_take_i |=> !rom_en_o)
      else $error("rom enable without fetch");
   fetch_addr_a: assert property (@(posedge clock_i) disable iff (reset_i)
      fetch_req_i && !vec_take_i |=> rom_addr_o == $past(pc_o))
      else $error("fetch address not old pc");
   jump_target_a: assert property (@(posedge clock_i) disable iff (reset_i)
      fetch_req_i && fetch_jump_i && !vec_take_i |=> pc_o == $past(fetch_target_i))
      else $error("jump target not loaded");
   pc_hold_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !fetch_req_i && !vec_take_i |=> $stable(pc_o))
      else $error("pc moved without fetch");
   // Slots sit eight bytes apart, so the sixteenth lands at 007BH
   vector_last_a: assert property (@(posedge clock_i) disable iff (reset_i)
      vec_take_i && vec_index_i == 4'hf |=> pc_o == 16'h007b)
      else $error("last vector slot misplaced");
   vector_slot_a: assert property (@(posedge clock_i) disable iff (reset_i)
      fetch_req_i && !vec_take_i && pc_o == 16'h000b |=> rom_en_o && rom_addr_o == 16'h000b)
      else $error("vector slot not plain memory");
   option_sel_a: assert property (@(posedge clock_i) disable iff (reset_i)
      fetch_req_i && !vec_take_i && pc_o == 16'h4007 |=> opt_sel_o)
      else $error("trim byte not selected");

   // Data path checks: routing is watched inside, answers at the outputs
   read_latency_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && !dreq_i.wr |=> ##1 rvalid_o)
      else $error("read answer not two cycles late");
   acc_read_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && !dreq_i.wr && dreq_i.mode == CMSD_MODE_DIRECT && dreq_i.addr == 8'he0
      |=> ##1 rdata_o == $past(arith_working_reg_o, 2))
      else $error("accumulator read wrong");
   psw_write_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.wr && dreq_i.mode == CMSD_MODE_DIRECT
      && dreq_i.addr == 8'hd0 |=> program_status_word_o == $past(dreq_i.wdata))
      else $error("status word write lost");
   flags_load_a: assert property (@(posedge clock_i) disable iff (reset_i)
      psw_flags_we_i && !(dreq_i.req && dreq_i.wr && dreq_i.mode == CMSD_MODE_DIRECT
      && dreq_i.addr == 8'hd0) |=> program_status_word_o == $past(psw_flags_i))
      else $error("status flags not loaded");
   reg_bank_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.mode == CMSD_MODE_REG
      |-> ram_addr == {3'h0, program_status_word_o[4:3], dreq_i.addr[2:0]})
      else $error("register bank address wrong");
   bit_byte_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.mode == CMSD_MODE_BIT && !dreq_i.addr[7]
      |-> to_ram && ram_addr == {4'h2, dreq_i.addr[6:3]})
      else $error("bit address maps to wrong byte");
   bit_sfr_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.mode == CMSD_MODE_BIT && dreq_i.addr[7] |-> to_sfr && !to_ram)
      else $error("upper bit address not in sfr space");
   bit_nowrite_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.wr && dreq_i.mode == CMSD_MODE_BIT |-> !ram_we)
      else $error("bit write reached ram");
   indirect_ram_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.mode == CMSD_MODE_INDIRECT
      |-> to_ram && !to_sfr && ram_addr == dreq_i.addr)
      else $error("indirect access not routed to ram");
   direct_sfr_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.mode == CMSD_MODE_DIRECT && dreq_i.addr[7] |-> to_sfr && !to_ram)
      else $error("upper direct access not routed to sfr");
   lower_direct_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.mode == CMSD_MODE_DIRECT && !dreq_i.addr[7]
      |-> to_ram && !to_sfr && ram_addr == dreq_i.addr)
      else $error("lower direct access not routed to ram");
   // Only the accumulator and status word take direct writes above 7FH
   sfr_drop_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.wr && dreq_i.mode == CMSD_MODE_DIRECT && dreq_i.addr[7]
      && dreq_i.addr != 8'he0 |=> $stable(arith_working_reg_o))
      else $error("stray sfr write changed accumulator");
   ram_only_a: assert property (@(posedge clock_i) disable iff (reset_i)
      dreq_i.req && dreq_i.wr && dreq_i.mode != CMSD_MODE_DIRECT
      |=> $stable(arith_working_reg_o))
      else $error("ram write leaked into sfr space");
endmodule : cmsd_decoder
`default_nettype wire

//--- testbench/cmsd_core_model.sv
`default_nettype none
module cmsd_core_model
   import cmsd_pkg::*;
(
   input wire logic clock_i,
   output logic fetch_req_o,
   output logic fetch_jump_o,
   output logic [CMSD_PC_W-1:0] fetch_target_o,
   output logic vec_take_o,
   output logic [3:0] vec_index_o,
   output var cmsd_dreq_t dreq_o,
   output logic [7:0] psw_flags_o,
   output logic psw_flags_we_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      fetch_req_o = 1'b0;
      fetch_jump_o = 1'b0;
      fetch_target_o = '0;
      vec_take_o = 1'b0;
      vec_index_o = '0;
      dreq_o = '0;
      psw_flags_o = '0;
      psw_flags_we_o = 1'b0;
   end
   // Each request is held over exactly one rising edge; released qualifiers are
   // inverted (the access mode is kept, fetch_jump_o drops to 0) so a stale value can never pass for a fresh one
   task automatic access(input logic w, input cmsd_mode_t m, input logic [7:0] a,
         input logic [7:0] d);
      @(negedge clock_i);
      dreq_o = '{req: 1'b1, wr: w, mode: m, addr: a, wdata: d};
      @(negedge clock_i);
      dreq_o = '{req: 1'b0, wr: ~w, mode: m, addr: ~a, wdata: ~d};
   endtask : access
   task automatic fetch(input logic j, input logic [15:0] t);
      @(negedge clock_i);
      fetch_req_o = 1'b1;
      fetch_jump_o = j;
      fetch_target_o = t;
      @(negedge clock_i);
      fetch_req_o = 1'b0;
      fetch_jump_o = 1'b0;
      fetch_target_o = ~t;
   endtask : fetch
   task automatic vector(input logic [3:0] i);
      @(negedge clock_i);
      vec_take_o = 1'b1;
      vec_index_o = i;
      @(negedge clock_i);
      vec_take_o = 1'b0;
      vec_index_o = ~i;
   endtask : vector
   task automatic flags(input logic [7:0] f);
      @(negedge clock_i);
      psw_flags_we_o = 1'b1;
      psw_flags_o = f;
      @(negedge clock_i);
      psw_flags_we_o = 1'b0;
      psw_flags_o = ~f;
   endtask : flags
endmodule : cmsd_core_model
`default_nettype wire

//--- testbench/cpu_memory_space_decoder_bench.sv
`default_nettype none
module cpu_memory_space_decoder_bench
   import cmsd_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic f_req, f_jmp, v_take, rom_en, opt_sel, rvalid, bitv, fl_we;
   logic [15:0] f_tgt, pc, rom_addr;
   logic [3:0] v_idx;
   logic [7:0] flags, rdata, acc, program_status_word, d;
   logic [1:0] bank;
   logic b;
   cmsd_dreq_t dreq;
   int mismatches = 0;
   int num_checks = 0;
   always #10 clock_i = ~clock_i;
   cmsd_core_model core (.clock_i(clock_i), .fetch_req_o(f_req), .fetch_jump_o(f_jmp),
      .fetch_target_o(f_tgt), .vec_take_o(v_take), .vec_index_o(v_idx), .dreq_o(dreq),
      .psw_flags_o(flags), .psw_flags_we_o(fl_we));
   cmsd_decoder dut (.clock_i(clock_i), .reset_i(reset_i), .fetch_req_i(f_req),
      .fetch_jump_i(f_jmp), .fetch_target_i(f_tgt), .vec_take_i(v_take),
      .vec_index_i(v_idx), .pc_o(pc), .rom_addr_o(rom_addr), .rom_en_o(rom_en),
      .opt_sel_o(opt_sel), .dreq_i(dreq), .psw_flags_i(flags), .psw_flags_we_i(fl_we),
      .rdata_o(rdata), .rvalid_o(rvalid), .bit_o(bitv), .arith_working_reg_o(acc),
      .program_status_word_o(program_status_word), .bank_o(bank));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rd(input cmsd_mode_t m, input logic [7:0] a);
      int n = 0;
      core.access(1'b0, m, a, 8'h00);
      while (rvalid !== 1'b1 && n < 4) begin
         @(negedge clock_i);
         n++;
      end
      if (rvalid !== 1'b1) begin
         mismatches++;
         wrap_up();
      end
      d = rdata;
      b = bitv;
   endtask : rd
   task automatic t_fetch();
      core.fetch(1'b0, 16'h0000);
      check(rom_addr, 16'h0000);
      check(pc, 16'h0001);
      check(16'(rom_en), 16'h0001);
      core.fetch(1'b1, 16'h0fff);
      core.fetch(1'b0, 16'h0000);
      check(16'(rom_en), 16'h0001);
      core.fetch(1'b1, 16'h4007);
      check(16'(rom_en), 16'h0000);
      core.fetch(1'b1, 16'hffff);
      check(16'({opt_sel, rom_en}), 16'h0002);
      core.fetch(1'b1, 16'h0123);
      check(rom_addr, 16'hffff);
      @(negedge clock_i);
      reset_i = 1'b1;
      repeat (2) @(negedge clock_i);
      reset_i = 1'b0;
      check(pc, 16'h0000);
      $display("fetch test done");
   endtask : t_fetch
   task automatic t_vectors();
      for (int i = 0; i < 16; i++) begin
         core.vector(4'(i));
         check(pc, 16'(3 + 8 * i));
      end
      core.fetch(1'b1, 16'h000b);
      core.fetch(1'b0, 16'h0000);
      check(16'({rom_addr[7:0], 7'h00, rom_en}), 16'h0b01);
      $display("vector test done");
   endtask : t_vectors
   task automatic t_data();
      core.access(1'b1, CMSD_MODE_DIRECT, 8'h30, 8'ha5);
      rd(CMSD_MODE_INDIRECT, 8'h30);
      check(16'(d), 16'h00a5);
      core.access(1'b1, CMSD_MODE_INDIRECT, 8'h90, 8'h3c);
      rd(CMSD_MODE_DIRECT, 8'h90);
      check(16'(d), 16'h0000);
      core.access(1'b1, CMSD_MODE_DIRECT, 8'h90, 8'hff);
      rd(CMSD_MODE_INDIRECT, 8'h90);
      check(16'(d), 16'h003c);
      core.access(1'b1, CMSD_MODE_DIRECT, 8'he0, 8'h5a);
      check(16'(acc), 16'h005a);
      rd(CMSD_MODE_DIRECT, 8'he0);
      check(16'(d), 16'h005a);
      $display("data test done");
   endtask : t_data
   task automatic t_banks();
      core.access(1'b1, CMSD_MODE_DIRECT, 8'hd0, 8'h18);
      check(16'({program_status_word, 6'h00, bank}), 16'h1803);
      core.access(1'b1, CMSD_MODE_REG, 8'h02, 8'h66);
      rd(CMSD_MODE_DIRECT, 8'h1a);
      check(16'(d), 16'h0066);
      core.flags(8'h08);
      check(16'(bank), 16'h0001);
      core.access(1'b1, CMSD_MODE_REG, 8'h02, 8'h55);
      rd(CMSD_MODE_DIRECT, 8'h0a);
      check(16'(d), 16'h0055);
      core.access(1'b1, CMSD_MODE_DIRECT, 8'h21, 8'h04);
      core.access(1'b1, CMSD_MODE_DIRECT, 8'h2f, 8'h80);
      rd(CMSD_MODE_BIT, 8'h0a);
      check(16'(b), 16'h0001);
      rd(CMSD_MODE_BIT, 8'h0b);
      check(16'(b), 16'h0000);
      rd(CMSD_MODE_BIT, 8'h7f);
      check(16'(b), 16'h0001);
      rd(CMSD_MODE_BIT, 8'he6);
      check(16'(b), 16'h0001);
      core.access(1'b1, CMSD_MODE_BIT, 8'h0b, 8'hff);
      rd(CMSD_MODE_DIRECT, 8'h21);
      check(16'(d), 16'h0004);
      $display("bank test done");
   endtask : t_banks
   initial begin
      repeat (5) @(negedge clock_i);
      reset_i = 1'b0;
      check(pc, 16'h0000);
      check(16'({acc, 6'h00, bank}), 16'h0000);
      $display("reset test done");
      t_fetch();
      t_vectors();
      t_data();
      t_banks();
      wrap_up();
   end
endmodule : cpu_memory_space_decoder_bench
`default_nettype wire
